// file: logic/e1cs_rx_cas.sv
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
module e1cs_rx_cas #(
    parameter int NUM_CH = 32
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Wishbone classic slave
    input  wire logic       wb_cyc_i,
    input  wire logic       wb_stb_i,
    input  wire logic       wb_we_i,
    input  wire logic [9:0] wb_adr_i,
    input  wire logic [3:0] wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]     wb_dat_o,
    output logic            wb_ack_o,
    output logic            irq_o,
    // Incoming E1 octet stream
    input  wire logic       rx_valid_i,
    input  wire logic [4:0] rx_ts_i,
    input  wire logic [3:0] rx_frame_i,
    input  wire logic [7:0] rx_data_i,
    // Conditioned stream to terminal equipment
    output logic            te_valid_o,
    output logic [4:0]      te_ts_o,
    output logic [7:0]      te_data_o
);
    import e1cs_pkg::*;

    // ==========================================================
    // Register storage
    // Per-channel tables are plain arrays; one row per timeslot keeps
    // a channel's settings together and avoids any shared state.
    // Only one status bit exists in this block; the other status
    // positions read as zero.
    logic [7:0]  block_irq_enable_reg;
    logic [7:0]  framer_irq_enable_reg;
    logic [7:0]  irq_clear_mode_ctrl_reg;
    logic        sig_updated_reg;
    logic [7:0]  rx_user_idle_octet_reg [NUM_CH];
    logic [3:0]  rx_channel_conditioning_ctrl_reg [NUM_CH];
    logic [1:0]  rx_sig_extract_ctrl_reg [NUM_CH];
    logic [3:0]  rx_sig_store_array_reg [NUM_CH];
    logic [NUM_CH-1:0] pend_change_reg;
    logic [NUM_CH-1:0] sig_change_reg;

    // ==========================================================
    // Bus decode
    // A request is taken once: the acknowledge register masks the
    // strobe in the cycle it is high, so a held request cannot write
    // or clear twice.
    // Writes land on the edge that raises the acknowledge.
    logic       bus_req;
    logic       bus_wr;
    logic       bus_rd;
    logic [7:0] idx;
    logic [7:0] wdat;
    logic       mf_end;
    logic       sig_ts;

    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign bus_wr  = bus_req && wb_we_i && wb_sel_i[0];
    assign bus_rd  = bus_req && !wb_we_i;
    assign idx     = wb_adr_i[9:2];
    assign wdat    = wb_dat_i[7:0];
    assign sig_ts  = rx_valid_i && (rx_ts_i == 5'(SIG_TIMESLOT));
    // Last octet of the last frame closes the multi-frame
    // The alignment word in frame 0 is not checked here; frame and
    // timeslot numbers are trusted as delivered by the framer.
    assign mf_end  = rx_valid_i && (rx_frame_i == LAST_FRAME) && (rx_ts_i == 5'(NUM_CH - 1));

    // Range test for a per-channel table starting at base
    function automatic logic in_range(input logic [7:0] a, input logic [7:0] base);
        in_range = (a >= base) && (a < base + 8'(NUM_CH));
    endfunction : in_range

    // ==========================================================
    // Global control registers
    // Reset values are not documented; all controls start at zero,
    // which leaves every interrupt disabled after reset.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            block_irq_enable_reg    <= RST_OCTET;
            framer_irq_enable_reg   <= RST_OCTET;
            irq_clear_mode_ctrl_reg <= RST_OCTET;
        end else if (bus_wr) begin
            case (idx)
                IDX_BLOCK_IRQ_EN:  block_irq_enable_reg    <= wdat;
                IDX_FRAMER_IRQ_EN: framer_irq_enable_reg   <= wdat;
                IDX_IRQ_CLR_MODE:  irq_clear_mode_ctrl_reg <= wdat;
                default: ;
            endcase
        end
    end

    // ==========================================================
    // Per-channel configuration, extraction and change detection
    // Timeslot 16 of frame f (1..15) carries channel f in its upper
    // nibble and channel f+16 in its lower nibble; frame 0 holds the
    // multi-frame alignment word and feeds no channel. Channels 0 and
    // 16 therefore never receive signaling.
    // The stored nibble keeps only the bits that the channel's mode
    // extracts, so a change in an unused bit raises no event.
    // With extraction off the store keeps its last value and may still
    // be written by software; no change is ever flagged.

    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
        logic [3:0] nib;
        logic       hit;
        logic [3:0] keep;
        logic [3:0] fresh;

        assign hit = sig_ts && (ch % 16 != 0) && (rx_frame_i == 4'(ch % 16));
        assign nib = (ch < 16) ? rx_data_i[7:4] : rx_data_i[3:0];

        // Keep mask: sixteen-code uses A-D, four-code A and B,
        // two-code A alone; unused bits are stored as zero.

        always_comb begin
            case (e1cs_extract_t'(rx_sig_extract_ctrl_reg[ch]))
                EXT_SIXTEEN: keep = 4'hf;
                EXT_FOUR:    keep = 4'hc;
                EXT_TWO:     keep = 4'h8;
                default:     keep = 4'h0;
            endcase
        end
        assign fresh = nib & keep;

        // Each channel decodes its own index, so a write reaches
        // exactly one entry of the per-channel table it addresses.
        // own channel only
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                rx_user_idle_octet_reg[ch]           <= RST_OCTET;
                rx_channel_conditioning_ctrl_reg[ch] <= RST_COND;
                rx_sig_extract_ctrl_reg[ch]          <= RST_EXTRACT;
            end else if (bus_wr) begin
                if (idx == IDX_IDLE_OCTET_0 + 8'(ch))
                    rx_user_idle_octet_reg[ch] <= wdat;
                if (idx == IDX_COND_CTRL_0 + 8'(ch))
                    rx_channel_conditioning_ctrl_reg[ch] <= wdat[3:0];
                if (idx == IDX_SIG_EXTRACT_0 + 8'(ch))
                    rx_sig_extract_ctrl_reg[ch] <= wdat[1:0];
            end
        end

        // Received signaling wins over a software write in the same cycle
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                rx_sig_store_array_reg[ch] <= 4'h0;
            end else if (hit && keep != 4'h0) begin
                rx_sig_store_array_reg[ch] <= fresh;
            end else if (bus_wr && idx == IDX_SIG_STORE_0 + 8'(ch)) begin
                rx_sig_store_array_reg[ch] <= wdat[3:0];
            end
        end

        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                pend_change_reg[ch] <= 1'b0;
            end else if (hit && keep != 4'h0 && fresh != (rx_sig_store_array_reg[ch] & keep)) begin
                pend_change_reg[ch] <= 1'b1;
            end else if (mf_end) begin
                pend_change_reg[ch] <= 1'b0;
            end
        end

        // Change bits are rewritten at every multi-frame end, so each
        // reflects only the multi-frame just closed; a read does not
        // clear them.
        // change bit per timeslot
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                sig_change_reg[ch] <= 1'b0;
            end else if (mf_end) begin
                sig_change_reg[ch] <= pend_change_reg[ch];
            end
        end
    end

    // ==========================================================
    // Status and interrupt
    // A change seen during a multi-frame is held in a pending bit and
    // only reported at the last octet of frame 15, so software sees one
    // event per multi-frame however many channels moved.
    // Enables are sampled at that instant: a multi-frame that closes while
    // either enable is off is lost for the status bit, although the
    // change registers still record it.
    // The interrupt output is the status bit gated by both enables,
    // registered once, so it trails the status bit by one cycle.
    logic framer_irq_enable_on;
    logic block_irq_enable_on;
    logic sig_event;
    logic st_read;
    logic st_w1c;

    assign framer_irq_enable_on   = framer_irq_enable_reg[BIT_SIG_UPDATED];
    assign block_irq_enable_on   = block_irq_enable_reg[BIT_BLK_FRAMER_EN];
    assign sig_event = mf_end && (pend_change_reg != '0);
    assign st_read   = bus_rd && idx == IDX_FRAMER_IRQ_ST && irq_clear_mode_ctrl_reg[BIT_RESET_ON_READ];
    assign st_w1c    = bus_wr && idx == IDX_FRAMER_IRQ_ST && !irq_clear_mode_ctrl_reg[BIT_RESET_ON_READ]
                       && wdat[BIT_SIG_UPDATED];

    // In reset-upon-read mode writes to the status register are
    // ignored; in write-to-clear mode reads leave it alone.
    // A read that clears returns the bit as it stood before the clear.
    // set status when enabled
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sig_updated_reg <= 1'b0;
        end else if (sig_event && framer_irq_enable_on && block_irq_enable_on) begin
            // Set wins over a clear in the same cycle
            sig_updated_reg <= 1'b1;
        end else if (st_read || st_w1c) begin
            sig_updated_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= sig_updated_reg && framer_irq_enable_on && block_irq_enable_on;
        end
    end

    // ==========================================================
    // Read mux and acknowledge
    logic [7:0] rd_next;
    logic [7:0] ci;
    logic [7:0] cb;

    // Register map, word index = byte address / 4:
    //   0x00       block interrupt enable, bit 1 gates framer status
    //   0x01       interrupt clear mode, bit 0 selects reset-upon-read
    //   0x04       framer interrupt status, bit 5 signaling updated
    //   0x05       framer interrupt enable, bit 5 signaling change
    //   0x0d-0x10  change registers, eight timeslots each
    //   0x60-0x7f  receive conditioning select per channel
    //   0x80-0x9f  user idle octet per channel
    //   0xa0-0xbf  signaling extraction control per channel
    //   0xc0-0xdf  stored signaling nibble per channel
    // Any other index reads as zero and ignores writes, so
    // software probing for absent registers sees no side effect.
    // Only byte lane 0 carries data; a write with sel[0] low is
    // still acknowledged so the master never stalls on it.
    // Reads take one cycle like writes; the acknowledge is a
    // registered pulse, so back-to-back requests need the idle
    // cycle that classic Wishbone gives between them.
    // Data lines are forced to zero outside a read acknowledge,
    // which keeps a shared bus free of stale read values.

    always_comb begin
        rd_next = UNMAPPED_READ;
        ci      = idx - IDX_IDLE_OCTET_0;
        cb      = idx - IDX_SIG_CHANGE_0;
        if (idx == IDX_BLOCK_IRQ_EN) begin
            rd_next = block_irq_enable_reg;
        end else if (idx == IDX_FRAMER_IRQ_EN) begin
            rd_next = framer_irq_enable_reg;
        end else if (idx == IDX_IRQ_CLR_MODE) begin
            rd_next = irq_clear_mode_ctrl_reg;
        end else if (idx == IDX_FRAMER_IRQ_ST) begin
            rd_next[BIT_SIG_UPDATED] = sig_updated_reg;
        end else if (idx >= IDX_SIG_CHANGE_0 && idx < IDX_SIG_CHANGE_0 + 8'(NUM_CHG_REGS)) begin
            // Lowest channel of each group sits in bit 7
            for (int b = 0; b < 8; b++) begin
                if (int'(cb) * 8 + b < NUM_CH)
                    rd_next[7 - b] = sig_change_reg[int'(cb) * 8 + b];
            end
        end else if (in_range(idx, IDX_IDLE_OCTET_0)) begin
            rd_next = rx_user_idle_octet_reg[ci[4:0]];
        end else if (in_range(idx, IDX_COND_CTRL_0)) begin
            ci      = idx - IDX_COND_CTRL_0;
            rd_next = {4'h0, rx_channel_conditioning_ctrl_reg[ci[4:0]]};
        end else if (in_range(idx, IDX_SIG_EXTRACT_0)) begin
            ci      = idx - IDX_SIG_EXTRACT_0;
            rd_next = {6'h00, rx_sig_extract_ctrl_reg[ci[4:0]]};
        end else if (in_range(idx, IDX_SIG_STORE_0)) begin
            ci      = idx - IDX_SIG_STORE_0;
            rd_next = {4'h0, rx_sig_store_array_reg[ci[4:0]]};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_rd ? {24'h00_0000, rd_next} : 32'h0000_0000;
        end
    end

    // ==========================================================
    // Payload conditioning towards terminal equipment
    // The conditioned octet is registered with its timeslot, one cycle
    // behind the line. Settings are looked up by the incoming timeslot,
    // so a channel's select only ever touches that channel's octets.
    // Between octets te_data_o holds its last value while te_ts_o follows
    // the line, so downstream logic may sample the octet late.
    // Milliwatt and pseudo-random patterns need generators outside
    // this block; those selects pass the line data through.
    logic [3:0] cnd;
    logic [7:0] cond_data;

    assign cnd = rx_channel_conditioning_ctrl_reg[rx_ts_i];
    // With 32 channels the five-bit timeslot index covers the table
    // exactly, so no out-of-range lookup can occur.

    always_comb begin
        case (e1cs_cond_t'(cnd))
            CND_INV_ALL:  cond_data = ~rx_data_i;
            CND_INV_EVEN: cond_data = rx_data_i ^ 8'haa;
            CND_INV_ODD:  cond_data = rx_data_i ^ 8'h55;
            CND_IDLE:     cond_data = rx_user_idle_octet_reg[rx_ts_i];
            CND_BUSY:     cond_data = CODE_BUSY;
            CND_VACANT:   cond_data = CODE_VACANT;
            CND_BUSY_TS:  cond_data = {3'b111, rx_ts_i};
            CND_MOOF:     cond_data = CODE_MOOF;
            CND_INV_MSB:  cond_data = rx_data_i ^ 8'h80;
            CND_INV_LOW:  cond_data = rx_data_i ^ 8'h7f;
            // Milliwatt, PRBS and D/E selections pass through unchanged here
            default:      cond_data = rx_data_i;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            te_valid_o <= 1'b0;
            te_ts_o    <= 5'h00;
            te_data_o  <= 8'h00;
        end else begin
            te_valid_o <= rx_valid_i;
            te_ts_o    <= rx_ts_i;
            te_data_o  <= rx_valid_i ? cond_data : te_data_o;
        end
    end
endmodule : e1cs_rx_cas

// file: inc/e1cs_pkg.sv
package e1cs_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_BLOCK_IRQ_EN   = 8'h00;
    localparam logic [7:0] IDX_IRQ_CLR_MODE   = 8'h01;
    localparam logic [7:0] IDX_FRAMER_IRQ_ST  = 8'h04;
    localparam logic [7:0] IDX_FRAMER_IRQ_EN  = 8'h05;
    localparam logic [7:0] IDX_SIG_CHANGE_0   = 8'h0d;
    localparam logic [7:0] IDX_COND_CTRL_0    = 8'h60;
    localparam logic [7:0] IDX_IDLE_OCTET_0   = 8'h80;
    localparam logic [7:0] IDX_SIG_EXTRACT_0  = 8'ha0;
    localparam logic [7:0] IDX_SIG_STORE_0    = 8'hc0;
    localparam int         NUM_CHG_REGS       = 4;
    // Field positions
    localparam int         BIT_BLK_FRAMER_EN  = 1;
    localparam int         BIT_SIG_UPDATED    = 5;
    localparam int         BIT_RESET_ON_READ  = 0;
    localparam int         SIG_TIMESLOT       = 16;
    localparam logic [3:0] LAST_FRAME         = 4'hf;
    // Reset values
    localparam logic [7:0] RST_OCTET          = 8'h00;
    localparam logic [3:0] RST_COND           = 4'h0;
    localparam logic [1:0] RST_EXTRACT        = 2'h0;
    // Fixed substitution codes
    localparam logic [7:0] CODE_BUSY          = 8'h7f;
    localparam logic [7:0] CODE_VACANT        = 8'hff;
    localparam logic [7:0] CODE_MOOF          = 8'h1a;
    localparam logic [7:0] UNMAPPED_READ      = 8'h00;

    typedef enum logic [1:0] {
        EXT_NONE    = 2'b00,
        EXT_SIXTEEN = 2'b01,
        EXT_FOUR    = 2'b10,
        EXT_TWO     = 2'b11
    } e1cs_extract_t;

    typedef enum logic [3:0] {
        CND_PASS     = 4'b0000,
        CND_INV_ALL  = 4'b0001,
        CND_INV_EVEN = 4'b0010,
        CND_INV_ODD  = 4'b0011,
        CND_IDLE     = 4'b0100,
        CND_BUSY     = 4'b0101,
        CND_VACANT   = 4'b0110,
        CND_BUSY_TS  = 4'b0111,
        CND_MOOF     = 4'b1000,
        CND_INV_MSB  = 4'b1011,
        CND_INV_LOW  = 4'b1100
    } e1cs_cond_t;
endpackage : e1cs_pkg

// file: test/e1cs_rx_cas_monitor.sv
`timescale 1ns/1ps
// ==========
// Bus, stream and interrupt checks
module e1cs_rx_cas_monitor
    import e1cs_pkg::*;
#(
    parameter int NUM_CH = 32
) (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [9:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        irq_o,
    input wire logic        rx_valid_i,
    input wire logic [4:0]  rx_ts_i,
    input wire logic [3:0]  rx_frame_i,
    input wire logic [7:0]  rx_data_i,
    input wire logic        te_valid_o,
    input wire logic [4:0]  te_ts_o,
    input wire logic [7:0]  te_data_o
);
    logic eom;
    assign eom = rx_valid_i && rx_frame_i == LAST_FRAME && rx_ts_i == 5'(NUM_CH - 1);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing");
    AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    AST_ACK_REQ: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    AST_RD_ZERO: assert property (!(wb_ack_o && !wb_we_i) |-> wb_dat_o == 32'h0)
        else $error("read data outside read ack");
    AST_IRQ_CAUSE: assert property ($rose(irq_o) |->
        $past(eom, 2) || $past(eom, 3) || $past(wb_ack_o && wb_we_i)) else $error("irq rose early");
    AST_IRQ_DROP: assert property ($fell(irq_o) |-> $past(wb_ack_o) || $past(wb_ack_o, 2))
        else $error("irq dropped alone");
    AST_TE_FOLLOW: assert property (rx_valid_i |=> te_valid_o && te_ts_o == $past(rx_ts_i))
        else $error("output octet lost");
    AST_TE_HOLD: assert property (!rx_valid_i |=> !te_valid_o && $stable(te_data_o))
        else $error("output moved when idle");
endmodule : e1cs_rx_cas_monitor

bind e1cs_rx_cas e1cs_rx_cas_monitor #(.NUM_CH(NUM_CH)) u_e1cs_rx_cas_monitor (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .irq_o(irq_o), .rx_valid_i(rx_valid_i), .rx_ts_i(rx_ts_i),
    .rx_frame_i(rx_frame_i), .rx_data_i(rx_data_i), .te_valid_o(te_valid_o), .te_ts_o(te_ts_o),
    .te_data_o(te_data_o));

// file: test/e1cs_e1_src.sv
`timescale 1ns/1ps
// ==========
// Line side: sends one whole multiframe per go
module e1cs_e1_src (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       go_i,
    input  wire logic       slow_i,
    input  wire logic [7:0] sig_i,
    output logic            done_o,
    output logic            rx_valid_o,
    output logic [4:0]      rx_ts_o,
    output logic [3:0]      rx_frame_o,
    output logic [7:0]      rx_data_o
);
    logic [8:0] cnt_reg;
    logic       busy_reg;
    logic       ph_reg;
    logic       emit;
    assign emit   = busy_reg && (!slow_i || ph_reg);
    assign done_o = !busy_reg;
    always @(posedge clk_i) begin
        ph_reg     <= !ph_reg && !rst_i;
        rx_valid_o <= emit && !rst_i;
        if (rst_i) begin
            busy_reg  <= 1'b0;
            rx_data_o <= 8'h00;
        end else if (go_i && !busy_reg) begin
            busy_reg <= 1'b1;
            cnt_reg  <= 9'h000;
        end else if (emit) begin
            cnt_reg  <= cnt_reg + 9'h001;
            busy_reg <= cnt_reg != 9'h1ff;
        end
        if (emit) begin
            rx_ts_o    <= cnt_reg[4:0];
            rx_frame_o <= cnt_reg[8:5];
            if (cnt_reg[4:0] == 5'd16)
                rx_data_o <= (cnt_reg[8:5] == 4'h0) ? 8'h0b : sig_i;
            else
                rx_data_o <= {3'h5, cnt_reg[4:0]};
        end else if (!rst_i) begin
            // Between octets the line shows garbage, inverting the last octet on every idle cycle
            rx_data_o <= ~rx_data_o;
        end
    end
endmodule : e1cs_e1_src

// file: test/tb.sv
`timescale 1ns/1ps
module tb;
    import e1cs_pkg::*;
    logic        clk_i, rst_i, cyc, stb, we, go, slow, pay, done;
    logic        wb_ack_o, irq_o, rx_valid, te_valid;
    logic [9:0]  adr;
    logic [31:0] wdat, wb_dat_o;
    logic [7:0]  sig, rx_data, te_data;
    logic [4:0]  rx_ts, te_ts;
    logic [3:0]  rx_frame;
    int          err_count, tests_run;

    e1cs_rx_cas u_e1cs_rx_cas (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
        .rx_valid_i(rx_valid), .rx_ts_i(rx_ts), .rx_frame_i(rx_frame), .rx_data_i(rx_data),
        .te_valid_o(te_valid), .te_ts_o(te_ts), .te_data_o(te_data));
    e1cs_e1_src u_e1cs_e1_src (
        .clk_i(clk_i), .rst_i(rst_i), .go_i(go), .slow_i(slow), .sig_i(sig), .done_o(done),
        .rx_valid_o(rx_valid), .rx_ts_o(rx_ts), .rx_frame_o(rx_frame), .rx_data_o(rx_data));

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= {idx, 2'b00};
        wdat <= {24'h0, d};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    task wr(input logic [7:0] idx, input logic [7:0] d);
        wb(1'b1, idx, d);
    endtask : wr

    task rd(input logic [7:0] idx, input logic [7:0] exp);
        wb(1'b0, idx, 8'h00);
        chk(wb_dat_o, {24'h0, exp});
    endtask : rd

    // One multiframe, then a short settle for the end-of-multiframe update
    task mf(input logic [7:0] s, input logic sl);
        sig  <= s;
        slow <= sl;
        go   <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        @(posedge clk_i);
        while (done !== 1'b1) @(posedge clk_i);
        repeat (4) @(posedge clk_i);
    endtask : mf

    task test_done;
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : test_done

    always @(posedge clk_i) begin
        if (pay && te_valid === 1'b1 && te_ts == 5'd3) chk(te_data, 8'h5a);
        if (pay && te_valid === 1'b1 && te_ts == 5'd4) chk(te_data, 8'ha4);
        if (pay && te_valid === 1'b1 && te_ts == 5'd5) chk(te_data, 8'h5a);
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        test_done();
    end

    initial begin
        {cyc, stb, we, go, slow, pay, adr, wdat, sig} = '0;
        rst_i = 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(IDX_IDLE_OCTET_0 + 8'd3, RST_OCTET);
        rd(IDX_SIG_EXTRACT_0 + 8'd1, {6'h0, RST_EXTRACT});
        rd(8'h3f, UNMAPPED_READ);
        wr(IDX_IDLE_OCTET_0 + 8'd3, 8'h5a);
        wr(IDX_IDLE_OCTET_0 + 8'd4, 8'ha5);
        rd(IDX_IDLE_OCTET_0 + 8'd3, 8'h5a);
        rd(IDX_IDLE_OCTET_0 + 8'd4, 8'ha5);
        wr(IDX_COND_CTRL_0 + 8'd3, {4'h0, CND_IDLE});
        wr(IDX_SIG_EXTRACT_0 + 8'd1, {6'h0, EXT_SIXTEEN});
        wr(IDX_SIG_EXTRACT_0 + 8'd2, {6'h0, EXT_FOUR});
        wr(IDX_SIG_EXTRACT_0 + 8'd3, {6'h0, EXT_TWO});
        wr(IDX_SIG_EXTRACT_0 + 8'd17, {6'h0, EXT_SIXTEEN});
        wr(IDX_COND_CTRL_0 + 8'd5, {4'h0, CND_INV_ALL});
        rd(IDX_SIG_EXTRACT_0 + 8'd2, {6'h0, EXT_FOUR});
        pay = 1'b1;
        mf(8'hb6, 1'b0);
        rd(IDX_SIG_STORE_0 + 8'd1, 8'h0b);
        rd(IDX_SIG_STORE_0 + 8'd2, 8'h08);
        rd(IDX_SIG_STORE_0 + 8'd3, 8'h08);
        rd(IDX_SIG_STORE_0 + 8'd5, 8'h00);
        rd(IDX_SIG_STORE_0 + 8'd17, 8'h06);
        rd(IDX_SIG_CHANGE_0 + 8'd2, 8'h40);
        rd(IDX_SIG_CHANGE_0, 8'h70);
        rd(IDX_FRAMER_IRQ_ST, 8'h00);
        wr(IDX_FRAMER_IRQ_EN, 8'h20);
        mf(8'h3c, 1'b1);
        rd(IDX_SIG_STORE_0 + 8'd1, 8'h03);
        rd(IDX_FRAMER_IRQ_ST, 8'h00);
        wr(IDX_BLOCK_IRQ_EN, 8'h02);
        mf(8'hb6, 1'b0);
        rd(IDX_FRAMER_IRQ_ST, 8'h20);
        chk(irq_o, 1'b1);
        wr(IDX_BLOCK_IRQ_EN, 8'h00);
        repeat (2) @(posedge clk_i);
        chk(irq_o, 1'b0);
        wr(IDX_BLOCK_IRQ_EN, 8'h02);
        mf(8'hb6, 1'b0);
        rd(IDX_SIG_CHANGE_0, 8'h00);
        rd(IDX_FRAMER_IRQ_ST, 8'h20);
        wr(IDX_FRAMER_IRQ_ST, 8'h00);
        rd(IDX_FRAMER_IRQ_ST, 8'h20);
        wr(IDX_FRAMER_IRQ_ST, 8'h20);
        rd(IDX_FRAMER_IRQ_ST, 8'h00);
        wr(IDX_IRQ_CLR_MODE, 8'h01);
        mf(8'h3c, 1'b0);
        rd(IDX_FRAMER_IRQ_ST, 8'h20);
        rd(IDX_FRAMER_IRQ_ST, 8'h00);
        repeat (2) @(posedge clk_i);
        chk(irq_o, 1'b0);
        test_done();
    end
endmodule : tb
